// ==== seiu_pkg.sv ====
// Constants and types shared by the status event and interrupt unit
package seiu_pkg;

  localparam int unsigned SEIU_DATA_W   = 32;
  localparam int unsigned SEIU_ADDR_W   = 7;
  localparam int unsigned SEIU_STAT_W   = 8;
  localparam int unsigned SEIU_DGRAM_W  = 40;

  // Datagram bit counts
  localparam logic [5:0] SEIU_CNT_ADDR_DONE = 6'h08;
  localparam logic [5:0] SEIU_CNT_FULL      = 6'h28;

  // Register offsets
  localparam logic [6:0] SEIU_OFS_GLOBAL_SETUP = 7'h00;
  localparam logic [6:0] SEIU_OFS_REPORT_SEL   = 7'h0B;
  localparam logic [6:0] SEIU_OFS_CLEAR_EXEMPT = 7'h0C;
  localparam logic [6:0] SEIU_OFS_IRQ_MASK     = 7'h0D;
  localparam logic [6:0] SEIU_OFS_EVENTS       = 7'h0E;
  localparam logic [6:0] SEIU_OFS_LIVE         = 7'h0F;

  // Interrupt control bits in global_setup
  localparam int unsigned SEIU_BIT_IRQ_POL       = 15;
  localparam int unsigned SEIU_BIT_IRQ_WEAK_EN   = 29;
  localparam int unsigned SEIU_BIT_IRQ_WIRED_AND = 30;

  // Live flag layout: velocity_state_flag in bits 1:0
  localparam int unsigned SEIU_VEL_LSB   = 0;
  localparam int unsigned SEIU_FIRST_PLAIN_EVENT = 3;
  localparam logic [1:0]  SEIU_VEL_STOP  = 2'h0;
  localparam logic [1:0]  SEIU_VEL_CONST = 2'h1;
  localparam logic [1:0]  SEIU_VEL_RAMP  = 2'h2;

  // Reset values
  localparam logic [31:0] SEIU_RST_GLOBAL_SETUP = 32'h00000000;
  localparam logic [31:0] SEIU_RST_REPORT_SEL   = 32'h00000000;
  localparam logic [31:0] SEIU_RST_CLEAR_EXEMPT = 32'h00000000;
  localparam logic [31:0] SEIU_RST_IRQ_MASK     = 32'h00000000;
  localparam logic [31:0] SEIU_RST_EVENTS       = 32'h00000000;

  typedef enum logic [1:0] {
    SEIU_ST_IDLE = 2'b01,
    SEIU_ST_XFER = 2'b10
  } seiu_state_e;

  typedef struct packed {
    logic [31:0] global_setup;
    logic [31:0] serial_report_select;
    logic [31:0] read_clear_exempt;
    logic [31:0] irq_source_mask;
    logic [31:0] latched_change_bits;
    logic [31:0] cond_prev;
    logic        sck_prev;
    logic [5:0]  bit_cnt;
    logic [39:0] rx_shift;
    logic [39:0] tx_shift;
    logic        irq_level;
    logic        irq_weak;
    seiu_state_e state;
  } seiu_state_s;

endpackage : seiu_pkg

// ==== seiu_status_pick.sv ====
// Picks the first eight selected events for the serial status byte
`timescale 1ns/1ps
`default_nettype none

module seiu_status_pick
  import seiu_pkg::*;
(
  input  wire logic [31:0] i_events,
  input  wire logic [31:0] i_select,
  output logic      [7:0]  o_status
);

  logic [3:0] slot;

  always_comb begin
    o_status = 8'h00;
    slot     = 4'h0;
    for (int i = 0; i < SEIU_DATA_W; i++) begin
      if (i_select[i] && (slot < 4'h8)) begin
        o_status[slot[2:0]] = i_events[i];
        slot = slot + 4'h1;
      end
    end
  end

endmodule // seiu_status_pick

`default_nettype wire

// ==== seiu_core.sv ====
// Status event latch, serial register access and interrupt pin of the event unit
//
// Operation
// - Inactive-to-active condition change sets its event bit.
// - Event bits stay set until explicitly cleared.
// - Velocity state yields three events, one per value 0 to 2.
// - Live condition register is read-only, unlatched.
// - Completed serial read of events clears them.
// - Exempted events survive the read-clear.
// - Writing one to an event bit clears it.
// - Events near clearing may be lost; exemption avoids.
// - Selected events lead every serial response.
// - Over eight selected: lowest eight positions win.
// - Interrupt is OR of masked events.
// - Interrupt active low unless polarity bit set.
// - Wired-OR: inactive weak, active strong.
// - Wired-AND: inactive strong, active weak.
`timescale 1ns/1ps
`default_nettype none

module seiu_core
  import seiu_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  input  wire logic [31:0] i_status_flags,
  input  wire logic        i_spi_cs_n,
  input  wire logic        i_spi_sck,
  input  wire logic        i_spi_sdi,
  output logic             o_spi_sdo,
  output logic             o_irq_out,
  output logic             o_irq_oe,
  output logic             o_irq_weak
);

  seiu_state_s s_r;
  seiu_state_s s_nxt;

  logic [31:0] cond;
  logic [31:0] rise;
  logic [31:0] clr_mask;
  logic [7:0]  status_bits;
  logic [6:0]  early_addr;
  logic [6:0]  full_addr;
  logic        sck_rise;
  logic        sck_fall;
  logic        frame_end;
  logic        frame_full;
  logic        irq_active;

  function automatic logic [31:0] reg_read(input logic [6:0]  addr,
                                           input seiu_state_s st,
                                           input logic [31:0] live);
    case (addr)
      SEIU_OFS_GLOBAL_SETUP: reg_read = st.global_setup;
      SEIU_OFS_REPORT_SEL:   reg_read = st.serial_report_select;
      SEIU_OFS_CLEAR_EXEMPT: reg_read = st.read_clear_exempt;
      SEIU_OFS_IRQ_MASK:     reg_read = st.irq_source_mask;
      SEIU_OFS_EVENTS:       reg_read = st.latched_change_bits;
      SEIU_OFS_LIVE:         reg_read = live;
      default:               reg_read = 32'h00000000;
    endcase
  endfunction

  seiu_status_pick u_pick (
    .i_events (s_r.latched_change_bits),
    .i_select (s_r.serial_report_select),
    .o_status (status_bits)
  );

  // Event conditions: three velocity decodes, then plain flags
  always_comb begin
    cond = i_status_flags;
    cond[0] = (i_status_flags[SEIU_VEL_LSB +: 2] == SEIU_VEL_STOP);
    cond[1] = (i_status_flags[SEIU_VEL_LSB +: 2] == SEIU_VEL_CONST);
    cond[2] = (i_status_flags[SEIU_VEL_LSB +: 2] == SEIU_VEL_RAMP);
  end

  assign rise       = cond & ~s_r.cond_prev;
  assign sck_rise   = i_spi_sck & ~s_r.sck_prev;
  assign sck_fall   = ~i_spi_sck & s_r.sck_prev;
  assign frame_end  = (s_r.state == SEIU_ST_XFER) && i_spi_cs_n;
  assign frame_full = frame_end && (s_r.bit_cnt == SEIU_CNT_FULL);
  assign early_addr = {s_r.rx_shift[5:0], i_spi_sdi};
  assign full_addr  = s_r.rx_shift[38:32];
  assign irq_active = |(s_r.latched_change_bits & s_r.irq_source_mask);

  always_comb begin
    clr_mask = 32'h00000000;
    if (frame_full && !s_r.rx_shift[39] && (full_addr == SEIU_OFS_EVENTS)) begin
      clr_mask = ~s_r.read_clear_exempt;
    end
    if (frame_full && s_r.rx_shift[39] && (full_addr == SEIU_OFS_EVENTS)) begin
      clr_mask = s_r.rx_shift[31:0];
    end
  end

  always_comb begin
    s_nxt           = s_r;
    s_nxt.sck_prev  = i_spi_sck;
    s_nxt.cond_prev = cond;
    // A new edge wins over a clear in the same cycle
    s_nxt.latched_change_bits = (s_r.latched_change_bits & ~clr_mask) | rise;

    case (s_r.state)
      SEIU_ST_IDLE: begin
        if (!i_spi_cs_n) begin
          s_nxt.state    = SEIU_ST_XFER;
          s_nxt.bit_cnt  = 6'h00;
          // The first sck fall shifts too, so the status byte sits one place lower
          s_nxt.tx_shift = {1'b0, status_bits, 31'h00000000};
        end
      end
      SEIU_ST_XFER: begin
        if (i_spi_cs_n) begin
          s_nxt.state = SEIU_ST_IDLE;
          if (frame_full && s_r.rx_shift[39]) begin
            case (full_addr)
              SEIU_OFS_GLOBAL_SETUP: s_nxt.global_setup = s_r.rx_shift[31:0];
              SEIU_OFS_REPORT_SEL:   s_nxt.serial_report_select = s_r.rx_shift[31:0];
              SEIU_OFS_CLEAR_EXEMPT: s_nxt.read_clear_exempt = s_r.rx_shift[31:0];
              SEIU_OFS_IRQ_MASK:     s_nxt.irq_source_mask = s_r.rx_shift[31:0];
              default: ;
            endcase
          end
        end else begin
          if (sck_rise && (s_r.bit_cnt < SEIU_CNT_FULL)) begin
            s_nxt.rx_shift = {s_r.rx_shift[38:0], i_spi_sdi};
            s_nxt.bit_cnt  = s_r.bit_cnt + 6'h01;
            if (s_r.bit_cnt == (SEIU_CNT_ADDR_DONE - 6'h01)) begin
              s_nxt.tx_shift = {s_r.tx_shift[39],
                                reg_read(early_addr, s_r, i_status_flags),
                                7'h00};
            end
          end
          if (sck_fall) begin
            s_nxt.tx_shift = {s_r.tx_shift[38:0], 1'b0};
          end
        end
      end
      default: begin
        s_nxt.state = SEIU_ST_IDLE;
      end
    endcase

    s_nxt.irq_level = s_r.global_setup[SEIU_BIT_IRQ_POL] ? irq_active : ~irq_active;
    s_nxt.irq_weak  = 1'b0;
    if (s_r.global_setup[SEIU_BIT_IRQ_WEAK_EN]) begin
      if (s_r.global_setup[SEIU_BIT_IRQ_WIRED_AND]) begin
        s_nxt.irq_weak = irq_active;
      end else begin
        s_nxt.irq_weak = ~irq_active;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      s_r.global_setup         <= SEIU_RST_GLOBAL_SETUP;
      s_r.serial_report_select <= SEIU_RST_REPORT_SEL;
      s_r.read_clear_exempt    <= SEIU_RST_CLEAR_EXEMPT;
      s_r.irq_source_mask      <= SEIU_RST_IRQ_MASK;
      s_r.latched_change_bits  <= SEIU_RST_EVENTS;
      s_r.cond_prev            <= 32'h00000000;
      s_r.sck_prev             <= 1'b1;
      s_r.bit_cnt              <= 6'h00;
      s_r.rx_shift             <= 40'h0000000000;
      s_r.tx_shift             <= 40'h0000000000;
      s_r.irq_level            <= 1'b1;
      s_r.irq_weak             <= 1'b0;
      s_r.state                <= SEIU_ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_spi_sdo  = s_r.tx_shift[39];
  assign o_irq_out  = s_r.irq_level;
  assign o_irq_oe   = 1'b1;
  assign o_irq_weak = s_r.irq_weak;

endmodule // seiu_core

`default_nettype wire

// ==== seiu_core_props.sv ====
// Port-level assertions of the status event and interrupt unit
`timescale 1ns/1ps
`default_nettype none
module seiu_core_props
  import seiu_pkg::*;
(
  input wire logic        i_ref_clk,
  input wire logic        i_sys_rst,
  input wire logic [31:0] i_status_flags,
  input wire logic        i_spi_cs_n,
  input wire logic        i_spi_sck,
  input wire logic        i_spi_sdi,
  input wire logic        o_spi_sdo,
  input wire logic        o_irq_out,
  input wire logic        o_irq_oe,
  input wire logic        o_irq_weak
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  // No frame, no flag change, no recent reset: nothing may move the pin
  sequence s_idle;
    i_spi_cs_n && $stable(i_status_flags) && !$past(i_sys_rst);
  endsequence
  property p_irq_cause; s_idle [*4] |-> $stable(o_irq_out); endproperty
  property p_weak_cause; s_idle [*4] |-> $stable(o_irq_weak); endproperty
  property p_frame_irq;
    (!i_spi_cs_n && $stable(i_status_flags) && !$past(i_sys_rst)) [*4] |-> $stable(o_irq_out);
  endproperty
  property p_weak_follows;
    (i_spi_cs_n && !$past(i_sys_rst)) [*4] ##0 $changed(o_irq_weak) |-> $changed(o_irq_out);
  endproperty
  property p_sdo_hold; (!i_spi_cs_n && i_spi_sck) [*4] |-> $stable(o_spi_sdo); endproperty
  property p_oe; o_irq_oe; endproperty
  property p_rst_irq; $past(i_sys_rst) |-> o_irq_out && !o_irq_weak; endproperty
  property p_rst_sdo; $past(i_sys_rst) |-> !o_spi_sdo; endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq moved without cause");
  a_weak_cause: assert property (p_weak_cause) else $error("weak moved without cause");
  a_frame_irq: assert property (p_frame_irq) else $error("irq moved in frame");
  a_weak_follows: assert property (p_weak_follows) else $error("weak alone");
  a_sdo_hold: assert property (p_sdo_hold) else $error("sdo moved with sck high");
  a_oe: assert property (p_oe) else $error("irq pin not driven");
  a_rst_irq: assert property (p_rst_irq) else $error("irq not idle at reset");
  a_rst_sdo: assert property (p_rst_sdo) else $error("sdo not low at reset");
  c_frame: cover property ($fell(i_spi_cs_n));
  c_irq: cover property ($changed(o_irq_out));
  c_weak: cover property ($rose(o_irq_weak));
endmodule // seiu_core_props
bind seiu_core seiu_core_props i_seiu_core_props (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
  .i_status_flags(i_status_flags), .i_spi_cs_n(i_spi_cs_n), .i_spi_sck(i_spi_sck),
  .i_spi_sdi(i_spi_sdi), .o_spi_sdo(o_spi_sdo), .o_irq_out(o_irq_out), .o_irq_oe(o_irq_oe),
  .o_irq_weak(o_irq_weak));
`default_nettype wire

// ==== seiu_host.sv ====
// SPI master model of the host controller
`timescale 1ns/1ps
`default_nettype none
module seiu_host (
  input  wire logic i_ref_clk,
  input  wire logic i_spi_sdo,
  output logic      o_spi_cs_n,
  output logic      o_spi_sck,
  output logic      o_spi_sdi
);
  initial begin
    o_spi_cs_n = 1'b1;
    o_spi_sck  = 1'b1;
    o_spi_sdi  = 1'b0;
  end
  // One 40-bit frame, mode 3, sampled just before each sck rise
  task automatic xfer(input logic [39:0] tx, output logic [39:0] rx);
    o_spi_cs_n = 1'b0;
    repeat (3) @(negedge i_ref_clk);
    for (int i = 39; i >= 0; i--) begin
      o_spi_sck = 1'b0;
      o_spi_sdi = tx[i];
      repeat (3) @(negedge i_ref_clk);
      rx[i] = i_spi_sdo;
      o_spi_sck = 1'b1;
      repeat (4) @(negedge i_ref_clk);
    end
    o_spi_cs_n = 1'b1;
    o_spi_sdi  = ~o_spi_sdi;
    repeat (3) @(negedge i_ref_clk);
  endtask
endmodule // seiu_host
`default_nettype wire

// ==== tb_status_event_interrupt_unit.sv ====
// Self-checking bench of the status event and interrupt unit
`timescale 1ns/1ps
`default_nettype none
module tb_status_event_interrupt_unit
  import seiu_pkg::*;
;
  logic        i_ref_clk, i_sys_rst, spi_cs_n, spi_sck, spi_sdi;
  logic        o_spi_sdo, o_irq_out, o_irq_oe, o_irq_weak;
  logic [31:0] i_status_flags, m_ev, m_prev, seed;
  logic [31:0] m_reg [16];
  int          miscompares, checked;
  seiu_core i_seiu_core (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_status_flags(i_status_flags), .i_spi_cs_n(spi_cs_n), .i_spi_sck(spi_sck),
    .i_spi_sdi(spi_sdi), .o_spi_sdo(o_spi_sdo), .o_irq_out(o_irq_out), .o_irq_oe(o_irq_oe),
    .o_irq_weak(o_irq_weak));
  seiu_host i_seiu_host (.i_ref_clk(i_ref_clk), .i_spi_sdo(o_spi_sdo), .o_spi_cs_n(spi_cs_n),
    .o_spi_sck(spi_sck), .o_spi_sdi(spi_sdi));
  function automatic logic [31:0] cond(logic [31:0] f);
    return {f[31:3], f[1:0] == SEIU_VEL_RAMP, f[1:0] == SEIU_VEL_CONST, f[1:0] == SEIU_VEL_STOP};
  endfunction
  always @(posedge i_ref_clk) begin
    m_ev = i_sys_rst ? 32'h0 : m_ev | (cond(i_status_flags) & ~m_prev);
    m_prev = i_sys_rst ? 32'h0 : cond(i_status_flags);
  end
  function automatic logic [7:0] pick(logic [31:0] e, logic [31:0] s);
    int n;
    logic [7:0] r;
    n = 0;
    r = 8'h00;
    for (int k = 0; k < 32; k++) if (s[k] && n < 8) begin
      r[n] = e[k];
      n++;
    end
    return r;
  endfunction
  task automatic give_verdict();
    if (miscompares == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk_rsp(input logic [39:0] got, input logic [39:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_irq();
    logic a;
    logic [2:0] e;
    repeat (2) @(negedge i_ref_clk);
    a = |(m_ev & m_reg[13]);
    e = {m_reg[0][SEIU_BIT_IRQ_POL] ~^ a,
         m_reg[0][SEIU_BIT_IRQ_WEAK_EN] & (m_reg[0][SEIU_BIT_IRQ_WIRED_AND] ~^ a), 1'b1};
    checked++;
    if ({o_irq_out, o_irq_weak, o_irq_oe} !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, {o_irq_out, o_irq_weak, o_irq_oe}, e);
    end
  endtask
  task automatic frame(input logic wr, input logic [6:0] a, input logic [31:0] d);
    logic [39:0] rx;
    logic [31:0] v;
    v = (a == SEIU_OFS_EVENTS) ? m_ev : (a == SEIU_OFS_LIVE) ? i_status_flags : m_reg[a[3:0]];
    if (a > SEIU_OFS_LIVE) v = 32'h0;
    i_seiu_host.xfer({wr, a, d}, rx);
    chk_rsp(rx, {pick(m_ev, m_reg[11]), v});
    if (wr && a inside {[7'h0B:7'h0D], 7'h00}) m_reg[a[3:0]] = d;
    if (a == SEIU_OFS_EVENTS) m_ev = m_ev & (wr ? ~d : m_reg[12]);
  endtask
  initial begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    repeat (60000) @(posedge i_ref_clk);
    miscompares++;
    give_verdict();
  end
  initial begin
    logic [6:0] ofs [6];
    ofs = '{SEIU_OFS_GLOBAL_SETUP, SEIU_OFS_REPORT_SEL, SEIU_OFS_CLEAR_EXEMPT, SEIU_OFS_IRQ_MASK,
            SEIU_OFS_LIVE, 7'h05};
    seed = 32'hA98A;
    miscompares = 0;
    checked = 0;
    i_sys_rst = 1'b1;
    i_status_flags = 32'h0;
    foreach (m_reg[k]) m_reg[k] = 32'h0;
    repeat (20) @(negedge i_ref_clk);
    i_sys_rst = 1'b0;
    chk_irq();
    frame(1'b0, SEIU_OFS_EVENTS, 32'h0);
    foreach (ofs[k]) begin
      frame(1'b1, ofs[k], $random(seed));
      frame(1'b0, ofs[k], 32'h0);
    end
    for (int i = 0; i < 15; i++) begin
      i_status_flags = $random(seed);
      i_status_flags[1:0] = 2'(i % 3);
      repeat (4) @(negedge i_ref_clk);
      chk_irq();
      frame(1'b0, SEIU_OFS_EVENTS, 32'h0);
      chk_irq();
      frame(1'b1, SEIU_OFS_EVENTS, $random(seed));
      chk_irq();
      frame(1'b1, ofs[i % 4], $random(seed));
    end
    give_verdict();
  end
endmodule // tb_status_event_interrupt_unit
`default_nettype wire
